//--- core/timer_pkg.sv
// Shared constants, field positions and types for the dual timer/counter
package timer_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_TL0  = 8'h8A;
  localparam logic [7:0] ADDR_TL1  = 8'h8B;
  localparam logic [7:0] ADDR_TH0  = 8'h8C;
  localparam logic [7:0] ADDR_TH1  = 8'h8D;

  // Control register bit positions
  localparam int CTRL_OVF_T1 = 7;
  localparam int CTRL_RUN_T1 = 6;
  localparam int CTRL_OVF_T0 = 5;
  localparam int CTRL_RUN_T0 = 4;
  localparam int CTRL_EDGE_B = 3;
  localparam int CTRL_TYPE_B = 2;
  localparam int CTRL_EDGE_A = 1;
  localparam int CTRL_TYPE_A = 0;

  // Mode register nibble placement and fields inside a nibble
  localparam int MODE_T1_LSB = 4;
  localparam int MODE_T0_LSB = 0;
  localparam int NIB_GATE    = 3;
  localparam int NIB_SEL     = 2;
  localparam int NIB_MODE_HI = 1;
  localparam int NIB_MODE_LO = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Machine cycle length in processor clocks
  localparam int         MC_DIV   = 12;
  localparam int         MC_W     = 4;
  localparam logic [3:0] MC_LAST  = 4'(MC_DIV - 1);
  localparam logic [3:0] MC_FIRST = 4'h0;

  // Operating modes of one timer
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_t;

endpackage

//--- core/dual_timer_counter.sv
// Two 16-bit timer/counters with four modes and a byte register port
// Functional notes
// - Timer operation counts once per twelve clocks
// - Counter operation counts external input falling edges
// - Edge detection spans two machine cycles
// - Mode nibbles: gate, select, two-bit mode
// - Modes: 13-bit, 16-bit, reload, split
// - Count while run and (no gate or gate high)
// - Mode 0 is 8-bit count after divide-by-32
// - Mode 0 uses high byte plus low five bits
// - Wrap to zero sets overflow flag
// - Run bit never alters count registers
// - Mode 1 uses all sixteen bits
// - Reload mode: low byte reloads from high
// - Timer 1 in mode 3 holds count
// - Timer 0 split low byte uses own controls
// - Split high byte: cycles, timer 1 run, flag
// - Timer 1 still counts, pulses while timer 0 split
// - Flags set by hardware, cleared by software or service
// - Control upper nibble: flags and run bits
// - Control lower nibble: external interrupt bits
// - Mode and control registers reset to zero
`timescale 1ns/1ps

module dual_timer_counter
  import timer_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // External count and gate inputs
  input  wire logic       count_input_a_in,
  input  wire logic       count_input_b_in,
  input  wire logic       gate_input_a_in,
  input  wire logic       gate_input_b_in,
  // Interrupt service acknowledges and edge flag sets
  input  wire logic       service_t0_in,
  input  wire logic       service_t1_in,
  input  wire logic       ext_irq_a_set_in,
  input  wire logic       ext_irq_b_set_in,
  // Flags, interrupt type bits and overflow events
  output logic            overflow_flag_t0_out,
  output logic            overflow_flag_t1_out,
  output logic            ext_irq_a_edge_flag_out,
  output logic            ext_irq_b_edge_flag_out,
  output logic            ext_irq_a_type_out,
  output logic            ext_irq_b_type_out,
  output logic            baud_tick_out
);

  // Architectural registers
  logic [7:0]      timer_control_reg;
  logic [7:0]      timer_mode_reg;
  logic [7:0]      count_low_t0;
  logic [7:0]      count_high_t0;
  logic [7:0]      count_low_t1;
  logic [7:0]      count_high_t1;

  // Machine cycle prescaler
  logic [MC_W-1:0] mc_count;
  logic            mc_tick;

  // Count input samples, taken once per machine cycle
  logic            samp_a;
  logic            prev_a;
  logic            samp_b;
  logic            prev_b;
  logic            fall_a;
  logic            fall_b;

  // Register port decode
  logic            wr_ctrl;
  logic            wr_mode;
  logic            wr_tl0;
  logic            wr_th0;
  logic            wr_tl1;
  logic            wr_th1;
  logic [7:0]      read_mux;

  // Per-timer mode fields and run bits
  logic            gate_t0;
  logic            sel_t0;
  timer_mode_t     mode_t0;
  logic            gate_t1;
  logic            sel_t1;
  timer_mode_t     mode_t1;
  logic            run_t0;
  logic            run_t1;

  // Count enables and next counts
  logic            inc_t0;
  logic            inc_t1;
  logic            inc_split_hi;
  logic [16:0]     step_t0;
  logic [16:0]     step_t1;
  logic [8:0]      split_hi_sum;
  logic            ovf_t0;
  logic            ovf_t1_count;
  logic            ovf_split_hi;
  logic            set_flag_t0;
  logic            set_flag_t1;
  logic [7:0]      next_low_t0;
  logic [7:0]      next_high_t0;
  logic [7:0]      next_low_t1;
  logic [7:0]      next_high_t1;
  logic [7:0]      next_ctrl;

  // One count step for modes 0, 1 and 2; returns {overflow, high, low}
  function automatic logic [16:0] count_step(
    input timer_mode_t m,
    input logic [7:0]  lo,
    input logic [7:0]  hi,
    input logic        inc
  );
    logic [5:0]  lo5;
    logic [8:0]  hi9;
    logic [16:0] sum;
    logic [16:0] res;
    lo5 = 6'h00;
    hi9 = 9'h000;
    sum = 17'h00000;
    res = {1'b0, hi, lo};
    if (inc) begin
      unique case (m)
        MODE_13BIT: begin
          // Low five bits act as the prescaler feeding the high byte
          lo5 = {1'b0, lo[4:0]} + 6'h01;
          hi9 = {1'b0, hi} + {8'h00, lo5[5]};
          res = {hi9[8], hi9[7:0], lo[7:5], lo5[4:0]};
        end
        MODE_16BIT: begin
          sum = {1'b0, hi, lo} + 17'h00001;
          res = sum;
        end
        MODE_RELOAD: begin
          // Only the low byte counts; overflow reloads it from high
          if (&lo) begin
            res = {1'b1, hi, hi};
          end else begin
            res = {1'b0, hi, lo + 8'h01};
          end
        end
        MODE_SPLIT: begin
          res = {1'b0, hi, lo};
        end
      endcase
    end
    return res;
  endfunction

  // Machine cycle prescaler: one tick every twelve clocks
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mc_count <= MC_FIRST;
    end else if (ce_in) begin
      mc_count <= (mc_count == MC_LAST) ? MC_FIRST : mc_count + 4'h1;
    end
  end

  assign mc_tick = ce_in && (mc_count == MC_LAST);

  // Sample count inputs once per machine cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      samp_a <= 1'b0;
      prev_a <= 1'b0;
      samp_b <= 1'b0;
      prev_b <= 1'b0;
    end else if (mc_tick) begin
      samp_a <= count_input_a_in;
      prev_a <= samp_a;
      samp_b <= count_input_b_in;
      prev_b <= samp_b;
    end
  end

  // A fall is a 1 sample followed by a 0 sample, counted a cycle later
  assign fall_a = prev_a & ~samp_a;
  assign fall_b = prev_b & ~samp_b;

  // Mode register fields and control run bits per timer
  assign gate_t0 = timer_mode_reg[MODE_T0_LSB + NIB_GATE];
  assign sel_t0  = timer_mode_reg[MODE_T0_LSB + NIB_SEL];
  assign mode_t0 = timer_mode_t'(timer_mode_reg[MODE_T0_LSB +: 2]);
  assign gate_t1 = timer_mode_reg[MODE_T1_LSB + NIB_GATE];
  assign sel_t1  = timer_mode_reg[MODE_T1_LSB + NIB_SEL];
  assign mode_t1 = timer_mode_t'(timer_mode_reg[MODE_T1_LSB +: 2]);
  assign run_t0  = timer_control_reg[CTRL_RUN_T0];
  assign run_t1  = timer_control_reg[CTRL_RUN_T1];

  // Count enables: run bit, optional gate, cycle or falling edge
  assign inc_t0 = mc_tick && run_t0 && (!gate_t0 || gate_input_a_in)
                  && (sel_t0 ? fall_a : 1'b1);
  assign inc_t1 = mc_tick && run_t1 && (!gate_t1 || gate_input_b_in)
                  && (sel_t1 ? fall_b : 1'b1)
                  && (mode_t0 != MODE_SPLIT);
  // Timer 1 keeps counting while timer 0's high byte counts cycles on timer 1's run bit
  assign inc_split_hi = mc_tick && run_t1 && (mode_t0 == MODE_SPLIT);

  // Next counts of both timers
  assign step_t0 = (mode_t0 == MODE_SPLIT)
                   ? {&count_low_t0 & inc_t0, count_high_t0,
                      count_low_t0 + {7'h00, inc_t0}}
                   : count_step(mode_t0, count_low_t0, count_high_t0, inc_t0);
  assign split_hi_sum = {1'b0, count_high_t0} + {8'h00, inc_split_hi};
  assign step_t1 = count_step(mode_t1, count_low_t1, count_high_t1,
                              inc_t1 || (mc_tick && (mode_t0 == MODE_SPLIT)
                                         && (mode_t1 != MODE_SPLIT)
                                         && (sel_t1 ? fall_b : 1'b1)));

  assign ovf_t0       = step_t0[16];
  assign ovf_t1_count = step_t1[16];
  assign ovf_split_hi = split_hi_sum[8] && (mode_t0 == MODE_SPLIT);

  // Flag sources; in split mode timer 1 no longer owns its flag
  assign set_flag_t0 = ovf_t0;
  assign set_flag_t1 = (mode_t0 == MODE_SPLIT) ? ovf_split_hi : ovf_t1_count;

  // Register port write decode
  assign wr_ctrl = wr_in && (addr_in == ADDR_CTRL);
  assign wr_mode = wr_in && (addr_in == ADDR_MODE);
  assign wr_tl0  = wr_in && (addr_in == ADDR_TL0);
  assign wr_th0  = wr_in && (addr_in == ADDR_TH0);
  assign wr_tl1  = wr_in && (addr_in == ADDR_TL1);
  assign wr_th1  = wr_in && (addr_in == ADDR_TH1);

  // Count bytes: a software write replaces the hardware step
  assign next_low_t0  = wr_tl0 ? wdata_in : step_t0[7:0];
  assign next_high_t0 = wr_th0 ? wdata_in
                      : (mode_t0 == MODE_SPLIT) ? split_hi_sum[7:0]
                      : step_t0[15:8];
  assign next_low_t1  = wr_tl1 ? wdata_in : step_t1[7:0];
  assign next_high_t1 = wr_th1 ? wdata_in : step_t1[15:8];

  // Control register: hardware set beats software clear and service
  always_comb begin
    next_ctrl = wr_ctrl ? wdata_in : timer_control_reg;
    if (service_t0_in) begin
      next_ctrl[CTRL_OVF_T0] = 1'b0;
    end
    if (service_t1_in) begin
      next_ctrl[CTRL_OVF_T1] = 1'b0;
    end
    if (set_flag_t0) begin
      next_ctrl[CTRL_OVF_T0] = 1'b1;
    end
    if (set_flag_t1) begin
      next_ctrl[CTRL_OVF_T1] = 1'b1;
    end
    if (ext_irq_a_set_in) begin
      next_ctrl[CTRL_EDGE_A] = 1'b1;
    end
    if (ext_irq_b_set_in) begin
      next_ctrl[CTRL_EDGE_B] = 1'b1;
    end
  end

  // Control and mode registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      timer_control_reg <= CTRL_RESET;
      timer_mode_reg    <= MODE_RESET;
    end else if (ce_in) begin
      timer_control_reg <= next_ctrl;
      if (wr_mode) begin
        timer_mode_reg <= wdata_in;
      end
    end
  end

  // Count registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      count_low_t0  <= COUNT_RESET;
      count_high_t0 <= COUNT_RESET;
      count_low_t1  <= COUNT_RESET;
      count_high_t1 <= COUNT_RESET;
    end else if (ce_in) begin
      count_low_t0  <= next_low_t0;
      count_high_t0 <= next_high_t0;
      count_low_t1  <= next_low_t1;
      count_high_t1 <= next_high_t1;
    end
  end

  // Read selection; unmapped addresses read zero
  assign read_mux = (addr_in == ADDR_CTRL) ? timer_control_reg
                  : (addr_in == ADDR_MODE) ? timer_mode_reg
                  : (addr_in == ADDR_TL0)  ? count_low_t0
                  : (addr_in == ADDR_TH0)  ? count_high_t0
                  : (addr_in == ADDR_TL1)  ? count_low_t1
                  : (addr_in == ADDR_TH1)  ? count_high_t1
                  : READ_ZERO;

  // Read data and baud event, both registered
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_out     <= READ_ZERO;
      baud_tick_out <= 1'b0;
    end else if (ce_in) begin
      if (rd_in) begin
        rdata_out <= read_mux;
      end
      baud_tick_out <= ovf_t1_count;
    end
  end

  // Flag and type outputs straight from the control register
  assign overflow_flag_t0_out    = timer_control_reg[CTRL_OVF_T0];
  assign overflow_flag_t1_out    = timer_control_reg[CTRL_OVF_T1];
  assign ext_irq_a_edge_flag_out = timer_control_reg[CTRL_EDGE_A];
  assign ext_irq_b_edge_flag_out = timer_control_reg[CTRL_EDGE_B];
  assign ext_irq_a_type_out      = timer_control_reg[CTRL_TYPE_A];
  assign ext_irq_b_type_out      = timer_control_reg[CTRL_TYPE_B];

endmodule

//--- test/dual_timer_counter_monitor.sv
// Checker for the register port, flags and overflow pulse of the dual timer
`timescale 1ns/1ps
module dual_timer_counter_monitor
  import timer_pkg::*;
(
  // Watched ports
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       service_t0_in,
  input wire logic       service_t1_in,
  input wire logic       ext_irq_a_set_in,
  input wire logic       overflow_flag_t0_out,
  input wire logic       overflow_flag_t1_out,
  input wire logic       ext_irq_a_edge_flag_out,
  input wire logic       ext_irq_a_type_out,
  input wire logic       ext_irq_b_type_out,
  input wire logic       baud_tick_out
);
  logic [3:0] mc;
  logic [7:0] mode_sh;
  wire        tick   = ce_in && mc == MC_LAST;
  wire        ctl_wr = wr_in && ce_in && addr_in == ADDR_CTRL;
  // Mirror of the machine-cycle prescaler and of the mode register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mc      <= MC_FIRST;
      mode_sh <= MODE_RESET;
    end else if (ce_in) begin
      mc <= tick ? MC_FIRST : mc + 4'h1;
      if (wr_in && addr_in == ADDR_MODE) mode_sh <= wdata_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_mode_rd;
    rd_in && ce_in && addr_in == ADDR_MODE;
  endsequence
  property p_reset_zero;
    $rose(rstn_in) |-> rdata_out == READ_ZERO && !overflow_flag_t0_out && !overflow_flag_t1_out;
  endproperty
  property p_mode_read;
    s_mode_rd |=> rdata_out == mode_sh;
  endproperty
  property p_flag0_cause;
    $rose(overflow_flag_t0_out) |-> $past(tick) || $past(ctl_wr && wdata_in[CTRL_OVF_T0]);
  endproperty
  property p_flag1_cause;
    $rose(overflow_flag_t1_out) |-> $past(tick) || $past(ctl_wr && wdata_in[CTRL_OVF_T1]);
  endproperty
  property p_flag0_hold;
    overflow_flag_t0_out && !service_t0_in && !ctl_wr |=> overflow_flag_t0_out;
  endproperty
  property p_service1;
    service_t1_in && ce_in && !tick && !ctl_wr |=> !overflow_flag_t1_out;
  endproperty
  property p_type_bits;
    ctl_wr |=> ext_irq_a_type_out == $past(wdata_in[CTRL_TYPE_A])
            && ext_irq_b_type_out == $past(wdata_in[CTRL_TYPE_B]);
  endproperty
  property p_edge_set;
    ext_irq_a_set_in && ce_in |=> ext_irq_a_edge_flag_out;
  endproperty
  property p_rdata_hold;
    !(rd_in && ce_in) |=> $stable(rdata_out);
  endproperty
  property p_baud_pulse;
    baud_tick_out |-> $past(tick) ##1 !baud_tick_out;
  endproperty
  a_reset_zero:  assert property (p_reset_zero) else $error("state not clear after reset");
  a_mode_read:   assert property (p_mode_read) else $error("mode readback wrong");
  a_flag0_cause: assert property (p_flag0_cause) else $error("flag 0 set off tick");
  a_flag1_cause: assert property (p_flag1_cause) else $error("flag 1 set off tick");
  a_flag0_hold:  assert property (p_flag0_hold) else $error("flag 0 lost");
  a_service1:    assert property (p_service1) else $error("service left flag 1");
  a_type_bits:   assert property (p_type_bits) else $error("type bits wrong");
  a_edge_set:    assert property (p_edge_set) else $error("edge flag not set");
  a_rdata_hold:  assert property (p_rdata_hold) else $error("read data moved");
  a_baud_pulse:  assert property (p_baud_pulse) else $error("bad overflow pulse");
endmodule

bind dual_timer_counter dual_timer_counter_monitor mon (.clk_in, .rstn_in, .ce_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .service_t0_in, .service_t1_in, .ext_irq_a_set_in,
  .overflow_flag_t0_out, .overflow_flag_t1_out, .ext_irq_a_edge_flag_out,
  .ext_irq_a_type_out, .ext_irq_b_type_out, .baud_tick_out);

//--- test/count_pin_model.sv
// Far-side model of the external count and gate pins
`timescale 1ns/1ps
module count_pin_model #(
  parameter int HALF = 24
) (
  // Clock and control from the bench
  input  wire logic clk_in,
  input  wire logic pulse_en_in,
  input  wire logic gate_in,
  // Pins towards the timers
  output logic      count_a_out = 1'b1,
  output wire logic count_b_out,
  output wire logic gate_a_out,
  output wire logic gate_b_out
);
  int cnt = 0;
  // Each level held HALF clocks, idle high outside bursts
  always @(posedge clk_in) begin
    if (!pulse_en_in || cnt == HALF - 1) cnt <= 0;
    else cnt <= cnt + 1;
    if (!pulse_en_in) count_a_out <= 1'b1;
    else if (cnt == HALF - 1) count_a_out <= ~count_a_out;
  end
  assign count_b_out = count_a_out;
  assign gate_a_out  = gate_in;
  assign gate_b_out  = 1'b1;
endmodule

//--- test/dual_timer_counter_test.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module dual_timer_counter_test;
  import timer_pkg::*;
  logic       clk_in, rstn_in, wr_in, rd_in, set_a, set_b, svc0, svc1, pulse_en, gate_lvl;
  logic [7:0] addr_in, wdata_in, d;
  wire  [7:0] rdata_out;
  wire        ca, cb, ga, gb, ovf0, ovf1, baud, edge_b;
  int         errors = 0;
  int         total_checks = 0;
  count_pin_model pins (.clk_in, .pulse_en_in(pulse_en), .gate_in(gate_lvl),
    .count_a_out(ca), .count_b_out(cb), .gate_a_out(ga), .gate_b_out(gb));
  dual_timer_counter dut (.clk_in, .rstn_in, .ce_in(1'b1), .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .count_input_a_in(ca), .count_input_b_in(cb), .gate_input_a_in(ga),
    .gate_input_b_in(gb), .service_t0_in(svc0), .service_t1_in(svc1),
    .ext_irq_a_set_in(set_a), .ext_irq_b_set_in(set_b), .overflow_flag_t0_out(ovf0),
    .overflow_flag_t1_out(ovf1), .ext_irq_a_edge_flag_out(), .ext_irq_b_edge_flag_out(edge_b),
    .ext_irq_a_type_out(), .ext_irq_b_type_out(), .baud_tick_out(baud));
  task automatic end_sim;
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One-cycle strobes on the register port
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  // One-cycle pulse: 0 both edge-flag sets, 1 service t0, 2 service t1
  task automatic pulse(input int k);
    @(posedge clk_in);
    if (k == 0) begin
      set_a <= 1'b1;
      set_b <= 1'b1;
    end else if (k == 1) begin
      svc0 <= 1'b1;
    end else begin
      svc1 <= 1'b1;
    end
    @(posedge clk_in);
    {set_a, set_b, svc0, svc1} <= 4'h0;
  endtask
  // Bounded wait for a level (0 flag t0, 1 baud, 2 flag t1); timeout fails
  task automatic wait_hi(input int k, input int n);
    logic s;
    s = (k == 0) ? ovf0 : (k == 1) ? baud : ovf1;
    for (int i = 0; i < n && s !== 1'b1; i++) begin
      @(posedge clk_in);
      #1 s = (k == 0) ? ovf0 : (k == 1) ? baud : ovf1;
    end
    `CHK(s, 1'b1)
    if (s !== 1'b1) end_sim();
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    {rstn_in, wr_in, rd_in, set_a, set_b, svc0, svc1, pulse_en, gate_lvl} = 9'h000;
    addr_in  = 8'h00;
    wdata_in = 8'h00;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk_rd(ADDR_CTRL, CTRL_RESET);
    chk_rd(ADDR_MODE, MODE_RESET);
    chk_rd(8'h90, READ_ZERO);
    wr(ADDR_MODE, 8'hA5);
    chk_rd(ADDR_MODE, 8'hA5);
    wr(ADDR_CTRL, 8'h05);
    pulse(0);
    chk_rd(ADDR_CTRL, 8'h0F);
    `CHK(edge_b, 1'b1)
    for (int i = 0; i < 4; i++) wr(ADDR_TL0 + 8'(i), 8'h30 + 8'(i));
    for (int i = 0; i < 4; i++) chk_rd(ADDR_TL0 + 8'(i), 8'h30 + 8'(i));
    // 16-bit timer wrap, then exact machine-cycle rate
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_TL0, 8'hFE);
    wr(ADDR_TH0, 8'hFF);
    wr(ADDR_CTRL, 8'h10);
    wait_hi(0, 28);
    repeat (62) @(posedge clk_in);
    chk_rd(ADDR_TL0, 8'h05);
    chk_rd(ADDR_TH0, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    chk_rd(ADDR_CTRL, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TL0, d);
    repeat (40) @(posedge clk_in);
    chk_rd(ADDR_TL0, d);
    // 13-bit wrap from high byte and low five bits
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_TL0, 8'hFF);
    wr(ADDR_TH0, 8'hFF);
    wr(ADDR_CTRL, 8'h10);
    wait_hi(0, 16);
    rd(ADDR_TL0, d);
    `CHK(d[4:0], 5'h00)
    chk_rd(ADDR_TH0, 8'h00);
    // Auto-reload of the low byte
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_TH0, 8'h80);
    wr(ADDR_TL0, 8'hFF);
    wr(ADDR_CTRL, 8'h10);
    wait_hi(0, 16);
    chk_rd(ADDR_TL0, 8'h80);
    chk_rd(ADDR_TH0, 8'h80);
    pulse(1);
    chk_rd(ADDR_CTRL, 8'h10);
    // Split timer 0 with timer 1 still running
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TH0, 8'hFE);
    wr(ADDR_TL1, 8'hFF);
    wr(ADDR_TH1, 8'hFF);
    wr(ADDR_MODE, 8'h13);
    wr(ADDR_CTRL, 8'h40);
    wait_hi(1, 16);
    // Timer 1's own wrap must not touch its flag while timer 0 is split
    chk_rd(ADDR_CTRL, 8'h40);
    wait_hi(2, 16);
    chk_rd(ADDR_CTRL, 8'hC0);
    chk_rd(ADDR_TL0, 8'h00);
    pulse(2);
    chk_rd(ADDR_CTRL, 8'h40);
    wr(ADDR_MODE, 8'h30);
    wr(ADDR_TL1, 8'h12);
    repeat (40) @(posedge clk_in);
    chk_rd(ADDR_TL1, 8'h12);
    // Gated falling-edge counting on the external input
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h0D);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TH0, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    pulse_en <= 1'b1;
    repeat (240) @(posedge clk_in);
    chk_rd(ADDR_TL0, 8'h00);
    @(posedge clk_in);
    gate_lvl <= 1'b1;
    repeat (480) @(posedge clk_in);
    rd(ADDR_TL0, d);
    `CHK(d inside {[8'h08:8'h0B]}, 1'b1)
    // Reset in mid-run returns registers to zero
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk_rd(ADDR_CTRL, CTRL_RESET);
    chk_rd(ADDR_MODE, MODE_RESET);
    end_sim();
  end
endmodule
